// *** logic/gdms_consts.svh ***
// Shared constants for the gate driver mode sequencer: offsets, reset values, fault layout and timing.
`ifndef GDMS_CONSTS_SVH
`define GDMS_CONSTS_SVH

// Fault vector layout: 0 supply UV, 1 supply OV, 2 charge pump UV, 3 drain-source OC, 4 shunt OC,
// 5 gate-source fault, 6 thermal warning, 7 thermal shutdown, 8 buck OC, 9 buck UV, 10 buck OV.
`define NUM_FAULTS 11
`define FLT_MSB 10
`define FLT_GLOBAL_BIT 15
// Faults that pull the buck chain down (supply UV/OV, thermal shutdown, all buck faults).
`define BUCK_FAULT_MAP 11'h783

// Register byte addresses on the AXI4-Lite slave.
`define AXI_AW 8
`define ADDR_MODE 8'h00
`define ADDR_FAULT 8'h04
`define ADDR_CTRL 8'h08
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Control register: fault enables in the low half, bridge disable map in the high half.
`define CTRL_EN_LSB 0
`define CTRL_MAP_LSB 16
`define CTRL_RST 32'h07BF07FF
`define CTRL_WMASK 32'h07FF07FF

// Timing: the clock rate and each delay in microseconds.
`define CLK_MHZ 50
`define T_STARTUP_US 1000
`define T_WAKE_US 1000
`define T_SLEEP_US 850
`define T_SHUT_US 10
`define T_RECOV_US 100
`define TMR_W 17

`endif

// *** logic/gdms_pkg.sv ***
// Types shared by the gate driver mode sequencer files.
package gdms_pkg;
    // Gray order along shutdown, sleep, operating, fault.
    typedef enum logic [1:0] {
        MODE_SHUTDOWN = 2'h0,
        MODE_SLEEP = 2'h1,
        MODE_OPERATING = 2'h3,
        MODE_FAULT = 2'h2
    } mode_t;
endpackage : gdms_pkg

// *** logic/mode_delay_timer.sv ***
// Down counter that gates one pending mode transition.
`include "gdms_consts.svh"
module mode_delay_timer (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic load_in,
    input wire logic cancel_in,
    input wire logic [`TMR_W-1:0] count_in,
    output logic done_out
);
    import gdms_pkg::*;
    logic [`TMR_W-1:0] remaining;
    logic busy;

    // A load restarts the interval, so a request that flips and returns starts over.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            remaining <= `TMR_W'(0);
            busy <= 1'b0;
        end else if (load_in) begin
            remaining <= count_in;
            busy <= 1'b1;
        end else if (cancel_in) begin
            busy <= 1'b0;
        end else if (busy) begin
            remaining <= remaining - `TMR_W'(1);
            busy <= (remaining > `TMR_W'(1));
        end
    end

    // Done stands in the last counted cycle only.
    assign done_out = busy && (remaining == `TMR_W'(1));

    count_step_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        busy && !done_out && !load_in && !cancel_in |=> remaining == $past(remaining) - `TMR_W'(1))
        else $error("Delay counter did not step down.");
    load_value_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        load_in |=> busy && remaining == $past(count_in))
        else $error("Delay counter did not take its load value.");
endmodule : mode_delay_timer

// *** logic/fault_flag_bank.sv ***
// Sticky individual fault flags with write-one-to-clear and the global fault flag.
`include "gdms_consts.svh"
module fault_flag_bank (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [`FLT_MSB:0] set_in,
    input wire logic [`FLT_MSB:0] clear_in,
    output logic [`FLT_MSB:0] flags_out,
    output logic global_out
);
    import gdms_pkg::*;
    genvar i;

    // One flag per fault; a fault present during a clear keeps its flag, so no event is lost.
    generate
        for (i = 0; i < `NUM_FAULTS; i++) begin : g_flag
            always_ff @(posedge clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    flags_out[i] <= 1'b0;
                end else if (set_in[i]) begin
                    flags_out[i] <= 1'b1;
                end else if (clear_in[i]) begin
                    flags_out[i] <= 1'b0;
                end
            end
            flag_set_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
                set_in[i] |=> flags_out[i])
                else $error("Fault flag missed its event.");
            flag_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
                flags_out[i] && !clear_in[i] |=> flags_out[i])
                else $error("Fault flag dropped without a clear.");
        end
    endgenerate

    // Global flag follows the individual flags with no delay.
    assign global_out = |flags_out;
endmodule : fault_flag_bank

// *** logic/gate_driver_mode_sequencer.sv ***
// Mode sequencer for a three-phase gate driver with its AXI4-Lite register slave.
//
// Our own choices: the address map and the AXI4-Lite register port.
`include "gdms_consts.svh"
module gate_driver_mode_sequencer #(
    parameter logic [`TMR_W-1:0] STARTUP_CYC = `TMR_W'(`T_STARTUP_US * `CLK_MHZ),
    parameter logic [`TMR_W-1:0] WAKE_CYC = `TMR_W'(`T_WAKE_US * `CLK_MHZ),
    parameter logic [`TMR_W-1:0] SLEEP_CYC = `TMR_W'(`T_SLEEP_US * `CLK_MHZ),
    parameter logic [`TMR_W-1:0] SHUT_CYC = `TMR_W'(`T_SHUT_US * `CLK_MHZ),
    parameter logic [`TMR_W-1:0] RECOV_CYC = `TMR_W'(`T_RECOV_US * `CLK_MHZ)
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic rail_rise_ok_in,
    input wire logic rail_fall_low_in,
    input wire logic enable_in,
    input wire logic [`FLT_MSB:0] fault_raw_in,
    input wire logic [5:0] control_input_pins_in,
    output logic [2:0] high_side_out,
    output logic [2:0] low_side_out,
    output logic standby_regulator_en_out,
    output logic logic_regulator_en_out,
    output logic logic_regulator_lowpwr_out,
    output logic buck_en_out,
    output logic charge_pump_en_out,
    output logic gate_aux_regulator_en_out,
    output logic error_alert_low_out,
    output gdms_pkg::mode_t mode_out,
    input wire logic [`AXI_AW-1:0] axi_awaddr_in,
    input wire logic axi_awvalid_in,
    output logic axi_awready_out,
    input wire logic [31:0] axi_wdata_in,
    input wire logic [3:0] axi_wstrb_in,
    input wire logic axi_wvalid_in,
    output logic axi_wready_out,
    output logic [1:0] axi_bresp_out,
    output logic axi_bvalid_out,
    input wire logic axi_bready_in,
    input wire logic [`AXI_AW-1:0] axi_araddr_in,
    input wire logic axi_arvalid_in,
    output logic axi_arready_out,
    output logic [31:0] axi_rdata_out,
    output logic [1:0] axi_rresp_out,
    output logic axi_rvalid_out,
    input wire logic axi_rready_in
);
    import gdms_pkg::*;

    mode_t mode, next_target, pend_tgt;
    logic pend_v;
    logic [`TMR_W-1:0] target_cnt;
    logic [31:0] ctrl;
    logic [`FLT_MSB:0] fault_en, bridge_map, active, flags, flag_set, flag_clr;
    logic global_flag;
    logic fault_hit;
    logic in_run_mode;
    logic going_down;
    logic run_up;
    logic bridge_dis_n;
    logic buck_dis_n;
    logic req;
    logic fresh;
    logic enter_fault;
    logic timer_done;
    logic step_done;
    logic exit_reset;
    logic [2:0] high_side_input, low_side_input;
    logic [`AXI_AW-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic do_write;
    logic [31:0] wr_bytes;
    logic [31:0] rd_word;
    logic rd_ok;
    logic wr_ok;

    // Control register fields and the fault sources that are currently enabled.
    assign fault_en = ctrl[`CTRL_EN_LSB +: `NUM_FAULTS];
    assign bridge_map = ctrl[`CTRL_MAP_LSB +: `NUM_FAULTS];
    assign active = fault_raw_in & fault_en;
    assign fault_hit = |active;
    assign in_run_mode = (mode == MODE_OPERATING) || (mode == MODE_FAULT);

    // Each fault pulls a block down with a low contribution; the block runs only if all are high.
    assign bridge_dis_n = &(~(active & bridge_map));
    assign buck_dis_n = &(~(active & `BUCK_FAULT_MAP));

    // Wanted mode and the delay that guards the step; a rail drop outranks everything.
    always_comb begin
        next_target = mode;
        target_cnt = RECOV_CYC;
        if (rail_fall_low_in && mode != MODE_SHUTDOWN) begin
            next_target = MODE_SHUTDOWN;
            target_cnt = SHUT_CYC;
        end else begin
            unique case (mode)
                MODE_SHUTDOWN: begin
                    if (rail_rise_ok_in) begin
                        next_target = MODE_SLEEP;
                        target_cnt = STARTUP_CYC;
                    end
                end
                MODE_SLEEP: begin
                    if (enable_in) begin
                        next_target = MODE_OPERATING;
                        target_cnt = WAKE_CYC;
                    end
                end
                MODE_OPERATING: begin
                    if (!enable_in) begin
                        next_target = MODE_SLEEP;
                        target_cnt = SLEEP_CYC;
                    end
                end
                MODE_FAULT: begin
                    if (!enable_in) begin
                        next_target = MODE_SLEEP;
                    end else if (!fault_hit) begin
                        next_target = MODE_OPERATING;
                    end
                end
            endcase
        end
    end

    // A new or changed request restarts the timer; a request that goes away cancels it.
    assign req = (next_target != mode);
    assign fresh = req && (!pend_v || pend_tgt != next_target);
    assign enter_fault = (mode == MODE_OPERATING) && fault_hit && !rail_fall_low_in;
    assign step_done = pend_v && req && !fresh && !enter_fault && timer_done;
    assign exit_reset = step_done && in_run_mode && (pend_tgt != MODE_OPERATING);

    mode_delay_timer u_timer (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .load_in(fresh && !enter_fault),
        .cancel_in(!req || enter_fault),
        .count_in(target_cnt),
        .done_out(timer_done)
    );

    // Mode register; a fault in Operating skips the timer because protection cannot wait.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode <= MODE_SHUTDOWN;
            pend_tgt <= MODE_SHUTDOWN;
            pend_v <= 1'b0;
        end else if (enter_fault) begin
            mode <= MODE_FAULT;
            pend_v <= 1'b0;
        end else if (!req) begin
            pend_v <= 1'b0;
        end else if (fresh) begin
            pend_v <= 1'b1;
            pend_tgt <= next_target;
        end else if (step_done) begin
            mode <= pend_tgt;
            pend_v <= 1'b0;
        end
    end

    // Blocks go down as soon as a step toward Sleep or Shutdown is pending, and are up in Operating or Fault whenever no such step is pending.
    assign going_down = pend_v && (pend_tgt == MODE_SLEEP || pend_tgt == MODE_SHUTDOWN);
    assign run_up = in_run_mode && !going_down;

    // Regulator chain; the logic regulator is off only in reset, and after that only changes its power level.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            standby_regulator_en_out <= 1'b1;
            logic_regulator_en_out <= 1'b0;
            logic_regulator_lowpwr_out <= 1'b1;
            buck_en_out <= 1'b0;
            charge_pump_en_out <= 1'b0;
            gate_aux_regulator_en_out <= 1'b0;
            mode_out <= MODE_SHUTDOWN;
        end else begin
            standby_regulator_en_out <= !run_up;
            logic_regulator_en_out <= 1'b1;
            logic_regulator_lowpwr_out <= !run_up;
            buck_en_out <= run_up && buck_dis_n;
            charge_pump_en_out <= run_up && buck_dis_n;
            gate_aux_regulator_en_out <= run_up && buck_dis_n;
            mode_out <= mode;
        end
    end

    // Each phase takes its high and low control from a fixed pair of the six input pins.
    genvar ph;
    generate
        for (ph = 0; ph < 3; ph++) begin : g_phase
            assign high_side_input[ph] = control_input_pins_in[2 * ph];
            assign low_side_input[ph] = control_input_pins_in[2 * ph + 1];
            // Both sides asked at once drives neither, so a bad input cannot shoot through.
            always_ff @(posedge clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    high_side_out[ph] <= 1'b0;
                    low_side_out[ph] <= 1'b0;
                end else begin
                    high_side_out[ph] <= run_up && bridge_dis_n && high_side_input[ph] && !low_side_input[ph];
                    low_side_out[ph] <= run_up && bridge_dis_n && low_side_input[ph] && !high_side_input[ph];
                end
            end
        end
    endgenerate

    // Flags latch only while the driver runs, when the monitors are meaningful.
    assign flag_set = active & {`NUM_FAULTS{in_run_mode}};
    assign wr_bytes = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    assign flag_clr = (do_write && wr_addr == `ADDR_FAULT) ? (wr_data[`FLT_MSB:0] & wr_bytes[`FLT_MSB:0]) : '0;

    fault_flag_bank u_flags (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .set_in(flag_set),
        .clear_in(flag_clr),
        .flags_out(flags),
        .global_out(global_flag)
    );

    // Alert pin is low while any flag stands.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            error_alert_low_out <= 1'b1;
        end else begin
            error_alert_low_out <= !global_flag;
        end
    end

    // Control register; leaving a running mode for Sleep or Shutdown wins over a software write.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl <= `CTRL_RST;
        end else if (exit_reset) begin
            ctrl <= `CTRL_RST;
        end else if (do_write && wr_addr == `ADDR_CTRL) begin
            ctrl <= ((ctrl & ~wr_bytes) | (wr_data & wr_bytes)) & `CTRL_WMASK;
        end
    end

    // Write channel: address and data are taken in either order, then one response.
    assign do_write = !axi_awready_out && !axi_wready_out && !axi_bvalid_out;
    assign wr_ok = (wr_addr == `ADDR_MODE) || (wr_addr == `ADDR_FAULT) || (wr_addr == `ADDR_CTRL);
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            axi_awready_out <= 1'b1;
            axi_wready_out <= 1'b1;
            axi_bvalid_out <= 1'b0;
            axi_bresp_out <= `RESP_OKAY;
            wr_addr <= '0;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
        end else begin
            if (axi_awvalid_in && axi_awready_out) begin
                axi_awready_out <= 1'b0;
                wr_addr <= {axi_awaddr_in[`AXI_AW-1:2], 2'h0};
            end
            if (axi_wvalid_in && axi_wready_out) begin
                axi_wready_out <= 1'b0;
                wr_data <= axi_wdata_in;
                wr_strb <= axi_wstrb_in;
            end
            if (do_write) begin
                axi_bvalid_out <= 1'b1;
                axi_bresp_out <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (axi_bvalid_out && axi_bready_in) begin
                axi_bvalid_out <= 1'b0;
                axi_awready_out <= 1'b1;
                axi_wready_out <= 1'b1;
            end
        end
    end

    // Read decode; the fault register shows the sticky flags so the controller sees every report.
    always_comb begin
        rd_word = 32'h00000000;
        rd_ok = 1'b1;
        unique case ({axi_araddr_in[`AXI_AW-1:2], 2'h0})
            `ADDR_MODE: rd_word = {27'h0, run_up, enable_in, pend_v, mode};
            `ADDR_FAULT: rd_word = {16'h0, global_flag, 4'h0, flags};
            `ADDR_CTRL: rd_word = ctrl;
            default: rd_ok = 1'b0;
        endcase
    end

    // Read channel answers one cycle after the address is taken.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            axi_arready_out <= 1'b1;
            axi_rvalid_out <= 1'b0;
            axi_rdata_out <= 32'h00000000;
            axi_rresp_out <= `RESP_OKAY;
        end else if (axi_arvalid_in && axi_arready_out) begin
            axi_arready_out <= 1'b0;
            axi_rvalid_out <= 1'b1;
            axi_rdata_out <= rd_word;
            axi_rresp_out <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (axi_rvalid_out && axi_rready_in) begin
            axi_rvalid_out <= 1'b0;
            axi_arready_out <= 1'b1;
        end
    end

    shutdown_req_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        rail_fall_low_in && mode != MODE_SHUTDOWN |=> mode == MODE_SHUTDOWN || (pend_v && pend_tgt == MODE_SHUTDOWN))
        else $error("Rail drop did not request Shutdown.");
    shutdown_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        mode == MODE_SHUTDOWN && !rail_rise_ok_in |=> mode == MODE_SHUTDOWN)
        else $error("Left Shutdown without the rail up.");
    sleep_bridge_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        mode == MODE_SLEEP |=> high_side_out == 3'h0 && low_side_out == 3'h0)
        else $error("Bridge driven in Sleep.");
    sleep_power_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        mode == MODE_SLEEP |=> !buck_en_out && !charge_pump_en_out && standby_regulator_en_out)
        else $error("Sleep regulator state wrong.");
    operating_power_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        mode == MODE_OPERATING && !pend_v && !fault_hit |=> buck_en_out && !standby_regulator_en_out
        && !logic_regulator_lowpwr_out)
        else $error("Operating regulator state wrong.");
    operating_drive_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        mode == MODE_OPERATING && !pend_v && !fault_hit && control_input_pins_in == 6'h01
        |=> high_side_out == 3'h1 && low_side_out == 3'h0)
        else $error("Bridge did not follow its inputs.");
    fault_entry_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        enter_fault |=> mode == MODE_FAULT ##1 !error_alert_low_out [*2])
        else $error("Fault not entered or not reported.");
    fault_bridge_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (active & bridge_map) != '0 |=> high_side_out == 3'h0 && low_side_out == 3'h0)
        else $error("Bridge driven against a fault.");
    alert_follow_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        error_alert_low_out == !$past(global_flag))
        else $error("Alert pin out of step with global flag.");
    timed_step_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $changed(mode) && mode != MODE_FAULT |-> $past(timer_done))
        else $error("Mode changed without its delay.");
    ctrl_reset_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        exit_reset |=> ctrl == `CTRL_RST && (mode == MODE_SLEEP || mode == MODE_SHUTDOWN))
        else $error("Control not reset on exit.");
    recover_gate_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        mode == MODE_FAULT && fault_hit && !rail_fall_low_in && enable_in |=> mode == MODE_FAULT)
        else $error("Left Fault Management with a fault present.");
endmodule : gate_driver_mode_sequencer

// *** testbench/enable_ctrl_model.sv ***
// Controller model that drives the enable line toward the sequencer.
module enable_ctrl_model #(
    parameter int LOW_MIN = 12
) (
    input wire logic clk_in,
    input wire logic want_in,
    output logic enable_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int low_cnt = 0;
    logic en_q = 1'b0;
    // One process owns the enable level, so the line has a single driver.
    assign enable_out = en_q;
    // A low pulse shorter than the sleep entry delay is never sent, so enable waits out LOW_MIN cycles.
    always @(posedge clk_in) begin
        low_cnt <= en_q ? 0 : low_cnt + 1;
        if (want_in && (en_q || low_cnt >= LOW_MIN)) en_q <= 1'b1;
        else if (!want_in) en_q <= 1'b0;
    end
endmodule : enable_ctrl_model

// *** testbench/test_gate_driver_mode_sequencer.sv ***
// Self-checking bench for the gate driver mode sequencer.
`include "gdms_consts.svh"
module test_gate_driver_mode_sequencer import gdms_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, rstn_in = 1'b0, rail_rise_ok_in = 1'b0, rail_fall_low_in = 1'b0, want = 1'b0;
    logic [10:0] fault_raw_in = 11'h000;
    logic [5:0] control_input_pins_in = 6'h00;
    wire logic enable_in;
    logic [2:0] high_side_out, low_side_out;
    logic standby_regulator_en_out, logic_regulator_en_out, logic_regulator_lowpwr_out, buck_en_out;
    logic charge_pump_en_out, gate_aux_regulator_en_out, error_alert_low_out;
    mode_t mode_out;
    logic [7:0] axi_awaddr_in = 8'h00, axi_araddr_in = 8'h00;
    logic [31:0] axi_wdata_in = 32'h0, axi_rdata_out, seed = 32'h41, got;
    logic [3:0] axi_wstrb_in = 4'hF;
    logic axi_awvalid_in = 0, axi_wvalid_in = 0, axi_bready_in = 0, axi_arvalid_in = 0, axi_rready_in = 0;
    logic axi_awready_out, axi_wready_out, axi_bvalid_out, axi_arready_out, axi_rvalid_out;
    logic [1:0] axi_bresp_out, axi_rresp_out, resp;
    int error_cnt = 0, check_count = 0, cyc = 0, fb;
    // Short delays keep the run brief; wait_mode gives up after 60 cycles, and the watchdog below bounds the handshake waits.
    gate_driver_mode_sequencer #(.STARTUP_CYC(8), .WAKE_CYC(8), .SLEEP_CYC(8), .SHUT_CYC(4), .RECOV_CYC(6)) DUT (.*);
    enable_ctrl_model ctrl (.clk_in(clk_in), .want_in(want), .enable_out(enable_in));
    always #10 clk_in = ~clk_in;
    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    // A hang counts as a mismatch and ends the run.
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic cmp(string what, logic [31:0] exp, logic [31:0] seen);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : cmp
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [5:0] bridge(logic [5:0] p);
        logic [2:0] h, l;
        for (int i = 0; i < 3; i++) begin
            h[i] = p[2*i] & ~p[2*i+1];
            l[i] = p[2*i+1] & ~p[2*i];
        end
        return {h, l};
    endfunction : bridge
    task automatic wr(logic [7:0] a, logic [31:0] d);
        axi_awaddr_in <= a;
        axi_wdata_in <= d;
        axi_awvalid_in <= 1'b1;
        axi_wvalid_in <= 1'b1;
        axi_bready_in <= 1'b1;
        fork
            begin do @(posedge clk_in); while (axi_awready_out !== 1'b1); axi_awvalid_in <= 1'b0; end
            begin do @(posedge clk_in); while (axi_wready_out !== 1'b1); axi_wvalid_in <= 1'b0; end
        join
        do @(posedge clk_in); while (axi_bvalid_out !== 1'b1);
        resp = axi_bresp_out;
        axi_bready_in <= 1'b0;
        @(posedge clk_in);
    endtask : wr
    task automatic rd(logic [7:0] a);
        axi_araddr_in <= a;
        axi_arvalid_in <= 1'b1;
        axi_rready_in <= 1'b1;
        do @(posedge clk_in); while (axi_arready_out !== 1'b1);
        axi_arvalid_in <= 1'b0;
        do @(posedge clk_in); while (axi_rvalid_out !== 1'b1);
        got = axi_rdata_out;
        resp = axi_rresp_out;
        axi_rready_in <= 1'b0;
        @(posedge clk_in);
    endtask : rd
    task automatic wait_mode(mode_t m);
        repeat (60) if (mode_out !== m) @(posedge clk_in);
        cmp("mode", m, mode_out);
    endtask : wait_mode
    // Main sequence: power up, wake, fault, recover, sleep, power down.
    initial begin
        repeat (10) @(posedge clk_in);
        rstn_in <= 1'b1;
        rail_rise_ok_in <= 1'b1;
        wait_mode(MODE_SLEEP);
        control_input_pins_in <= 6'(rnd());
        repeat (3) @(posedge clk_in);
        cmp("sleep blocks", 5'h18, {standby_regulator_en_out, logic_regulator_lowpwr_out, buck_en_out,
            charge_pump_en_out, gate_aux_regulator_en_out});
        cmp("sleep bridge", 0, {high_side_out, low_side_out});
        want <= 1'b1;
        repeat (4) @(posedge clk_in);
        cmp("early mode", MODE_SLEEP, mode_out);
        wait_mode(MODE_OPERATING);
        // Register traffic waits a few cycles after enable, standing in for the interface-ready time.
        repeat (3) @(posedge clk_in);
        cmp("run blocks", 5'h07, {standby_regulator_en_out, logic_regulator_lowpwr_out, buck_en_out,
            charge_pump_en_out, gate_aux_regulator_en_out});
        for (int i = 0; i < 6; i++) begin
            control_input_pins_in <= 6'(rnd());
            repeat (3) @(posedge clk_in);
            cmp("bridge", bridge(control_input_pins_in), {high_side_out, low_side_out});
        end
        // Upper strobes only: the bridge map opens to every fault, the enables keep their reset value.
        axi_wstrb_in <= 4'hC;
        wr(8'h08, 32'h07FF0000);
        cmp("wr resp", 2'h0, resp);
        axi_wstrb_in <= 4'hF;
        rd(8'h08);
        cmp("ctrl write", 32'h07FF07FF, got);
        fb = rnd() % 11;
        fault_raw_in <= 11'h001 << fb;
        wait_mode(MODE_FAULT);
        repeat (3) @(posedge clk_in);
        cmp("alert", 0, error_alert_low_out);
        cmp("fault bridge", 0, {high_side_out, low_side_out});
        rd(8'h04);
        cmp("fault reg", 32'h8000 | (32'h1 << fb), got);
        fault_raw_in <= 11'h000;
        wait_mode(MODE_OPERATING);
        wr(8'h04, 32'h000007FF);
        repeat (3) @(posedge clk_in);
        cmp("alert", 1, error_alert_low_out);
        fault_raw_in <= 11'h010;
        wait_mode(MODE_FAULT);
        want <= 1'b0;
        wait_mode(MODE_SLEEP);
        rd(8'h08);
        cmp("ctrl reset", 32'h07BF07FF, got);
        rd(8'h0C);
        cmp("unmapped", 2'h2, resp);
        // The rail is low, so the rising comparator must not claim it is up as well.
        rail_fall_low_in <= 1'b1;
        rail_rise_ok_in <= 1'b0;
        wait_mode(MODE_SHUTDOWN);
        cmp("standby", 2'h3, {standby_regulator_en_out, logic_regulator_en_out});
        wrap_up();
    end
endmodule : test_gate_driver_mode_sequencer
